// file: include/pci_cfg_params.svh
// Offsets, field positions, masks and reset values of the configuration header.
// Assumes byte offsets within a 256-byte configuration space.
`ifndef PCI_CFG_PARAMS_SVH
`define PCI_CFG_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_COMMAND      8'h04
`define OFS_CLASS        8'h08
`define OFS_LATENCY      8'h0c
`define OFS_IO_BASE      8'h10
`define OFS_MEM_BASE     8'h14
`define OFS_CARD_INFO    8'h28

// ----------------------------------------
// Command bit positions
// ----------------------------------------
`define BIT_IO_DECODE    0
`define BIT_MEM_DECODE   1
`define BIT_MASTER       2
`define BIT_PARITY_RESP  6

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define MASK_COMMAND     32'h0000_0047
`define MASK_LATENCY     32'h0000_ffff
`define MASK_IO_BASE     32'hffff_ff00
`define MASK_MEM_BASE    32'hffff_fc00
`define RST_COMMAND      32'h0000_0004
`define RST_LATENCY      32'h0000_0000
`define RST_BASE         32'h0000_0000
`define IO_INDICATOR     32'h0000_0001
`define MEM_INDICATOR    32'h0000_0000

// ----------------------------------------
// Class code fields
// ----------------------------------------
`define CLASS_NETWORK    8'h02
`define SUBCLASS_FAST    8'h00

`endif

// file: include/pci_cfg_pkg.sv
// Types shared by the configuration header bank.
// Assumes the params header is on the include path.
package pci_cfg_pkg;

  // ----------------------------------------
  // Configuration cycle request
  // ----------------------------------------
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

  // ----------------------------------------
  // Target access from the bus
  // ----------------------------------------
  typedef struct packed {
    logic        mem_cycle;
    logic        io_cycle;
    logic [31:0] addr;
  } target_req_s;

endpackage

// file: rtl/pci_config_header_regs.sv
// Part of the PCI configuration header: command bits, class, latency and
// line size, window bases and card information pointer.
// Assumes configuration cycles are decoded upstream into one-cycle requests.
`include "pci_cfg_params.svh"

module pci_config_header_regs #(
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value
  parameter logic [3:0] STEP     = 4'h0  // Arbitrary value
) (
  input  wire logic                     clock_i,
  input  wire logic                     reset_i,
  input  wire pci_cfg_pkg::cfg_req_s    cfg_req_i,
  output logic                          cfg_ack_o,
  output logic [31:0]                   cfg_rdata_o,
  input  wire pci_cfg_pkg::target_req_s target_req_i,
  output logic                          mem_claim_o,
  output logic                          io_claim_o,
  input  wire logic                     parity_error_i,
  output logic                          system_error_set_o,
  output logic                          master_enable_o,
  input  wire logic                     frame_asserted_i,
  input  wire logic                     grant_i,
  output logic                          master_stop_o,
  output logic [7:0]                    cache_line_length_o,
  input  wire logic [31:0]              eeprom_card_info_i
);
  import pci_cfg_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] command_q;
  logic [31:0] latency_q;
  logic [31:0] io_base_q;
  logic [31:0] mem_base_q;
  logic [31:0] card_info_q;
  logic [31:0] class_word;
  logic [31:0] rdata_d;
  logic [31:0] lane_mask;
  logic        reset_seen_q;
  logic        frame_q;
  logic        armed_q;
  logic [7:0]  latency_count_q;

  assign class_word = {`CLASS_NETWORK, `SUBCLASS_FAST, 8'h00, REVISION, STEP};
  assign lane_mask  = {{8{cfg_req_i.byte_en[3]}}, {8{cfg_req_i.byte_en[2]}},
                       {8{cfg_req_i.byte_en[1]}}, {8{cfg_req_i.byte_en[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] rw_mask,
                                        input logic [31:0] lanes);
    logic [31:0] m;
    m = rw_mask & lanes;
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Only masked bits can change, so reserved and read-only bits stay zero
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      command_q  <= `RST_COMMAND;
      latency_q  <= `RST_LATENCY;
      io_base_q  <= `RST_BASE;
      mem_base_q <= `RST_BASE;
    end
    else if (cfg_req_i.write)
    begin
      case (cfg_req_i.addr)
        `OFS_COMMAND:
          command_q <= merge(command_q, cfg_req_i.wdata, `MASK_COMMAND, lane_mask);
        `OFS_LATENCY:
          latency_q <= merge(latency_q, cfg_req_i.wdata, `MASK_LATENCY, lane_mask);
        `OFS_IO_BASE:
          io_base_q <= merge(io_base_q, cfg_req_i.wdata, `MASK_IO_BASE, lane_mask);
        `OFS_MEM_BASE:
          mem_base_q <= merge(mem_base_q, cfg_req_i.wdata, `MASK_MEM_BASE, lane_mask);
        default:
          command_q <= command_q;
      endcase
    end
  end

  // ----------------------------------------
  // Card information reload
  // ----------------------------------------
  // Captured on the first edge after reset release, never from the reset itself
  always_ff @(posedge clock_i)
  begin
    reset_seen_q <= reset_i;
    if (reset_i)
    begin
      card_info_q <= 32'h0000_0000;
    end
    else if (reset_seen_q)
    begin
      card_info_q <= eeprom_card_info_i;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    case (cfg_req_i.addr)
      `OFS_COMMAND:   rdata_d = command_q;
      `OFS_CLASS:     rdata_d = class_word;
      `OFS_LATENCY:   rdata_d = latency_q;
      `OFS_IO_BASE:   rdata_d = io_base_q | `IO_INDICATOR;
      `OFS_MEM_BASE:  rdata_d = mem_base_q | `MEM_INDICATOR;
      `OFS_CARD_INFO: rdata_d = card_info_q;
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_o   <= cfg_req_i.read | cfg_req_i.write;
      cfg_rdata_o <= cfg_req_i.read ? rdata_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Command gating outputs
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      mem_claim_o         <= 1'b0;
      io_claim_o          <= 1'b0;
      system_error_set_o  <= 1'b0;
      master_enable_o     <= 1'b0;
      cache_line_length_o <= 8'h00;
    end
    else
    begin
      mem_claim_o <= target_req_i.mem_cycle & command_q[`BIT_MEM_DECODE]
                     & (target_req_i.addr[31:10] == mem_base_q[31:10]);
      io_claim_o  <= target_req_i.io_cycle & command_q[`BIT_IO_DECODE]
                     & (target_req_i.addr[31:8] == io_base_q[31:8]);
      system_error_set_o  <= parity_error_i & command_q[`BIT_PARITY_RESP];
      master_enable_o     <= command_q[`BIT_MASTER];
      cache_line_length_o <= latency_q[7:0];
    end
  end

  // ----------------------------------------
  // Latency counter
  // ----------------------------------------
  // A zero value expires at once, so a zero setting yields the bus on grant loss
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      frame_q         <= 1'b0;
      armed_q         <= 1'b0;
      latency_count_q <= 8'h00;
      master_stop_o   <= 1'b0;
    end
    else
    begin
      frame_q <= frame_asserted_i;
      if (frame_asserted_i && !frame_q)
      begin
        latency_count_q <= latency_q[15:8];
        armed_q         <= 1'b1;
      end
      else if (!frame_asserted_i)
      begin
        armed_q <= 1'b0;
      end
      else if (latency_count_q != 8'h00)
      begin
        latency_count_q <= latency_count_q - 8'h01;
      end
      master_stop_o <= frame_asserted_i & frame_q & armed_q
                       & (latency_count_q == 8'h00) & !grant_i;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_parity_ignored;
    parity_error_i && !command_q[`BIT_PARITY_RESP] |=> !system_error_set_o;
  endproperty
  a_parity_ignored: assert property (p_parity_ignored) else $error("parity error not ignored");

  property p_parity_report;
    parity_error_i && command_q[`BIT_PARITY_RESP] |=> system_error_set_o;
  endproperty
  a_parity_report: assert property (p_parity_report) else $error("parity error not reported");

  property p_master_gate;
    cfg_req_i.write && cfg_req_i.addr == `OFS_COMMAND && cfg_req_i.byte_en[0]
      && !cfg_req_i.wdata[`BIT_MASTER] |=> ##1 !master_enable_o;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("master not disabled");

  property p_mem_gate;
    mem_claim_o |-> $past(command_q[`BIT_MEM_DECODE]) && $past(target_req_i.mem_cycle);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory claim while disabled");

  property p_io_gate;
    io_claim_o |-> $past(command_q[`BIT_IO_DECODE]) && $past(target_req_i.io_cycle);
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claim while disabled");

  property p_latency_store;
    cfg_req_i.write && cfg_req_i.addr == `OFS_LATENCY && cfg_req_i.byte_en[1:0] == 2'b11
      |=> latency_q[15:0] == $past(cfg_req_i.wdata[15:0]);
  endproperty
  a_latency_store: assert property (p_latency_store) else $error("latency not stored");

  property p_class_base;
    cfg_req_i.read && cfg_req_i.addr == `OFS_CLASS
      |=> cfg_ack_o && cfg_rdata_o[31:16] == {`CLASS_NETWORK, `SUBCLASS_FAST};
  endproperty
  a_class_base: assert property (p_class_base) else $error("class code wrong");

  property p_class_rev;
    cfg_req_i.read && cfg_req_i.addr == `OFS_CLASS
      |=> cfg_rdata_o[15:0] == {8'h00, REVISION, STEP};
  endproperty
  a_class_rev: assert property (p_class_rev) else $error("revision field wrong");

  property p_latency_load;
    frame_asserted_i && !frame_q |=> latency_count_q == $past(latency_q[15:8]);
  endproperty
  a_latency_load: assert property (p_latency_load) else $error("latency not loaded");

  property p_master_stop;
    master_stop_o |-> $past(frame_asserted_i) && !$past(grant_i) && $past(latency_count_q) == 8'h00;
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("early master stop");

  property p_io_read;
    cfg_req_i.read && cfg_req_i.addr == `OFS_IO_BASE |=> cfg_rdata_o[7:0] == 8'h01;
  endproperty
  a_io_read: assert property (p_io_read) else $error("io base low bits wrong");

  property p_mem_read;
    cfg_req_i.read && cfg_req_i.addr == `OFS_MEM_BASE |=> cfg_rdata_o[9:0] == 10'h000;
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory base low bits wrong");

  property p_card_info_ro;
    cfg_req_i.write && cfg_req_i.addr == `OFS_CARD_INFO && !reset_seen_q |=> $stable(card_info_q);
  endproperty
  a_card_info_ro: assert property (p_card_info_ro) else $error("card info written");

  property p_unmapped;
    cfg_req_i.read && cfg_req_i.addr == 8'h40 |=> cfg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_cmd_reserved;
    command_q[5:3] == 3'b000;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved) else $error("reserved command bits set");

  c_mem_claim: cover property (mem_claim_o);
  c_io_claim: cover property (io_claim_o);
  c_master_stop: cover property (master_stop_o);
  c_sys_err: cover property (system_error_set_o);

endmodule // pci_config_header_regs

// file: verification/pci_host_agent.sv
// Host side model: configuration cycles and bus-side stimulus for the header bank.
// Assumes one clock, and that tasks are called only after reset has been released.
module pci_host_agent (
  input  wire logic                     clock_i,
  output pci_cfg_pkg::cfg_req_s         cfg_req_o,
  output pci_cfg_pkg::target_req_s      target_req_o,
  output logic                          parity_error_o,
  output logic                          frame_o,
  output logic                          grant_o,
  input  wire logic                     cfg_ack_i,
  input  wire logic [31:0]              cfg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import pci_cfg_pkg::*;

  logic ack_seen;

  initial
  begin
    cfg_req_o      = '0;
    target_req_o   = '0;
    parity_error_o = 1'b0;
    frame_o        = 1'b0;
    grant_o        = 1'b0;
    ack_seen       = 1'b0;
  end

  // ----------------------------------------
  // Configuration cycle, one-cycle request
  // ----------------------------------------
  task automatic cfg_cycle(input logic wr, input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    cfg_req_o <= '{write: wr, read: !wr, addr: a, byte_en: be, wdata: d};
    @(posedge clock_i);
    // Released lines show inverted data, so a stale value never passes for live
    cfg_req_o <= '{write: 1'b0, read: 1'b0, addr: ~a, byte_en: ~be, wdata: ~d};
    #1;
    ack_seen = cfg_ack_i;
    q = cfg_rdata_i;
  endtask

  // ----------------------------------------
  // Bus side levels, changed just after an edge
  // ----------------------------------------
  task automatic set_bus(input logic m, input logic io, input logic [31:0] a,
                         input logic pe, input logic fr, input logic gn);
    @(posedge clock_i);
    target_req_o   <= '{mem_cycle: m, io_cycle: io, addr: (m | io) ? a : ~target_req_o.addr};
    parity_error_o <= pe;
    frame_o        <= fr;
    grant_o        <= gn;
  endtask
endmodule // pci_host_agent

// file: verification/tb_top.sv
// Self-checking bench for the configuration header bank.
// Assumes the params header on the include path and the host agent compiled first.
`include "pci_cfg_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pci_cfg_pkg::*;

  localparam logic [31:0] CARD  = 32'hc000_1235;
  localparam logic [31:0] CLASS = {`CLASS_NETWORK, `SUBCLASS_FAST, 8'h00, 4'h3, 4'h5};
  localparam logic [7:0]  OFS [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h28, 8'h40};
  localparam logic [31:0] ONES [7] = '{32'h0000_0047, CLASS, 32'h0000_ffff,
    32'hffff_ff01, 32'hffff_fc00, CARD, 32'h0000_0000};

  logic        clock_i;
  logic        reset_i;
  logic [31:0] eeprom;
  cfg_req_s    cfg_req;
  target_req_s target_req;
  logic        ack, mem_claim, io_claim, perr, sys_err, master_en, frame, grant, stop;
  logic [31:0] rdata;
  logic [7:0]  cll;
  int          n_errors, total_checks, cycles;

  pci_config_header_regs #(.REVISION(4'h3), .STEP(4'h5)) uut (
    .clock_i(clock_i), .reset_i(reset_i), .cfg_req_i(cfg_req), .cfg_ack_o(ack),
    .cfg_rdata_o(rdata), .target_req_i(target_req), .mem_claim_o(mem_claim),
    .io_claim_o(io_claim), .parity_error_i(perr), .system_error_set_o(sys_err),
    .master_enable_o(master_en), .frame_asserted_i(frame), .grant_i(grant),
    .master_stop_o(stop), .cache_line_length_o(cll), .eeprom_card_info_i(eeprom));

  pci_host_agent u_host (
    .clock_i(clock_i), .cfg_req_o(cfg_req), .target_req_o(target_req),
    .parity_error_o(perr), .frame_o(frame), .grant_o(grant),
    .cfg_ack_i(ack), .cfg_rdata_i(rdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.cfg_cycle(1'b0, a, 4'hf, 32'h0, q);
    chk("ack", 32'h1, {31'h0, u_host.ack_seen});
    chk("rdata", e, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    u_host.cfg_cycle(1'b1, a, be, d, q);
    chk("ack", 32'h1, {31'h0, u_host.ack_seen});
  endtask

  task automatic dec(input logic m, input logic io, input logic [31:0] a, input logic em, input logic ei);
    u_host.set_bus(m, io, a, 1'b0, 1'b0, 1'b0);
    step(1);
    chk("mem_claim", {31'h0, em}, {31'h0, mem_claim});
    chk("io_claim", {31'h0, ei}, {31'h0, io_claim});
  endtask

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    // Whole run needs about 120 cycles; far beyond that means a hang
    if (cycles == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    reset_i = 1'b1;
    eeprom  = CARD;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    step(2);
    chk("master_en", 32'h1, {31'h0, master_en});
    rd(`OFS_COMMAND, `RST_COMMAND);
    rd(`OFS_LATENCY, `RST_LATENCY);
    rd(`OFS_IO_BASE, `IO_INDICATOR);
    rd(`OFS_MEM_BASE, `MEM_INDICATOR);
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS[i], 4'hf, 32'hffff_ffff);
      rd(OFS[i], ONES[i]);
    end
    wr(`OFS_LATENCY, 4'h1, 32'h0000_1208);
    rd(`OFS_LATENCY, 32'h0000_ff08);
    foreach (ONES[i])
      if (i < 3)
      begin
        wr(`OFS_LATENCY, 4'h1, 32'h8 << i);
        step(1);
        chk("line_len", 32'h8 << i, {24'h0, cll});
      end
    wr(`OFS_IO_BASE, 4'hf, 32'h1234_5600);
    wr(`OFS_MEM_BASE, 4'hf, 32'habcd_0400);
    dec(1'b1, 1'b0, 32'habcd_07fc, 1'b1, 1'b0);
    dec(1'b1, 1'b0, 32'habcd_0800, 1'b0, 1'b0);
    dec(1'b0, 1'b1, 32'h1234_56ff, 1'b0, 1'b1);
    dec(1'b0, 1'b1, 32'h1234_5700, 1'b0, 1'b0);
    wr(`OFS_COMMAND, 4'hf, 32'h0000_0040);
    dec(1'b1, 1'b0, 32'habcd_0400, 1'b0, 1'b0);
    dec(1'b0, 1'b1, 32'h1234_5600, 1'b0, 1'b0);
    chk("master_en", 32'h0, {31'h0, master_en});
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 1'b0);
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
    step(0);
    chk("sys_err", 32'h1, {31'h0, sys_err});
    wr(`OFS_COMMAND, 4'hf, 32'h0000_0004);
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 1'b0);
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
    step(0);
    chk("sys_err", 32'h0, {31'h0, sys_err});
    wr(`OFS_LATENCY, 4'h2, 32'h0000_0200);
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b0, 1'b1, 1'b0);
    step(3);
    chk("stop", 32'h0, {31'h0, stop});
    step(1);
    chk("stop", 32'h1, {31'h0, stop});
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b0, 1'b1, 1'b1);
    step(1);
    chk("stop", 32'h0, {31'h0, stop});
    u_host.set_bus(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
    step(2);
    // ----------------------------------------
    // Second reset: card info must reload the new loader value
    // ----------------------------------------
    @(posedge clock_i);
    eeprom  <= 32'h3fff_fff4;
    reset_i <= 1'b1;
    step(2);
    chk("master_en", 32'h0, {31'h0, master_en});
    @(posedge clock_i);
    reset_i <= 1'b0;
    step(2);
    chk("master_en", 32'h1, {31'h0, master_en});
    rd(`OFS_CARD_INFO, 32'h3fff_fff4);
    rd(`OFS_LATENCY, `RST_LATENCY);
    rd(`OFS_COMMAND, `RST_COMMAND);
    end_sim();
  end
endmodule // tb_top
